// ---- hw/biosensor_core.sv ----
// Biosensor mode control, sample FIFO and two-wire register port
`timescale 1ns/1ps
module biosensor_core
#(
   parameter int DEPTH    = biosensor_pkg::FIFO_DEPTH,
   parameter int SAMPLE_W = 8 * biosensor_pkg::SAMPLE_BYTES
)
(
   input  wire logic                CLK,       // System clock
   input  wire logic                NRST,      // Async reset, active low
   input  wire logic                SCL,       // Bus clock pin
   input  wire logic                SDA_IN,    // Bus data pin level
   output wire logic                SDA_OUT,   // Bus data drive value
   output wire logic                SDA_OE,    // Bus data pull-down enable
   output wire logic                INT_OUT,   // Interrupt drive value
   output wire logic                INT_OE,    // Interrupt pull-down enable
   input  wire logic                BIO_CLK,   // Bio conversion clock
   input  wire logic                BIO_VALID, // New bio conversion
   input  wire logic [SAMPLE_W-1:0] BIO_DATA,  // Bio conversion result
   output wire logic                LIGHT_RUN, // Light measurement active
   output wire logic                PROX_RUN,  // Proximity measurement active
   output wire logic                BIO_RUN,   // Bio measurement active
   output wire logic                DUAL_LED,  // Bio uses both LEDs
   output wire logic                STANDBY    // Low-power standby
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] DEPTH_L = (PTR_W+1)'(DEPTH);

   typedef enum logic [2:0]
   {
      S_IDLE     = 3'h0,
      S_ADDR     = 3'h1,
      S_ACK_ADDR = 3'h3,
      S_RX       = 3'h2,
      S_ACK_RX   = 3'h6,
      S_TX       = 3'h7,
      S_ACK_TX   = 3'h5
   } bus_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // Bio clock domain: hold each conversion and flag it with a toggle

   logic [1:0]          bio_rst_sync;
   logic [SAMPLE_W-1:0] bio_hold;
   logic                bio_tgl;
   wire                 bio_rst_n = bio_rst_sync[1];

   // Reset release aligned to the bio clock
   always_ff @(posedge BIO_CLK or negedge NRST)
   begin
      if (!NRST) bio_rst_sync <= 2'h0;
      else       bio_rst_sync <= {bio_rst_sync[0], 1'b1};
   end

   // Hold stays stable for many system clocks, conversions are slow
   always_ff @(posedge BIO_CLK or negedge bio_rst_n)
   begin
      if (!bio_rst_n)
      begin
         bio_hold <= '0;
         bio_tgl  <= 1'b0;
      end
      else if (BIO_VALID)
      begin
         bio_hold <= BIO_DATA;
         bio_tgl  <= ~bio_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers into the system clock

   logic [2:0] scl_s;
   logic [2:0] sda_s;
   logic [2:0] tgl_s;

   // Stage 0 feeds only stage 1; stage 2 is edge history
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         tgl_s <= 3'h0;
      end
      else
      begin
         scl_s <= {scl_s[1:0], SCL};
         sda_s <= {sda_s[1:0], SDA_IN};
         tgl_s <= {tgl_s[1:0], bio_tgl};
      end
   end

   wire scl_rise   = scl_s[1] & ~scl_s[2];
   wire scl_fall   = ~scl_s[1] & scl_s[2];
   wire start_det  = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   wire stop_det   = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
   wire sample_evt = tgl_s[1] ^ tgl_s[2];

   ////////////////////////////////////////////////////////////////////////////
   // Register and FIFO state

   logic [7:0]          main_light;
   logic [7:0]          main_bio;
   logic [7:0]          int_cfg;
   logic [7:0]          fifo_cfg;
   logic [7:0]          ovf;
   logic [PTR_W-1:0]    wr_ptr;
   logic [PTR_W-1:0]    rd_ptr;
   logic [PTR_W:0]      level;
   logic [1:0]          byte_sel;
   logic                pair_phase;
   logic                st_drdy;
   logic                st_almost_full_flag;
   logic                sw_rst;
   logic [SAMPLE_W-1:0] ram [DEPTH];

   // Two-wire engine state
   bus_state_e state;
   bus_state_e next_state;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic [7:0] idx;
   logic       idx_loaded;
   logic       rw;
   logic       mack;
   logic       sda_oe;
   logic       int_oe;
   logic       light_run;
   logic       prox_run;
   logic       bio_run;
   logic       dual_led;
   logic       standby;

   ////////////////////////////////////////////////////////////////////////////
   // Mode decoding

   wire [1:0] mode      = main_bio[biosensor_pkg::MODE_LSB+1:biosensor_pkg::MODE_LSB];
   wire       bio_on    = main_bio[biosensor_pkg::BIT_ENABLE]
                          & (mode == biosensor_pkg::MODE_BIO_SINGLE
                             | mode == biosensor_pkg::MODE_BIO_DUAL);
   wire       dual      = bio_on & (mode == biosensor_pkg::MODE_BIO_DUAL);
   wire       light_on  = main_light[biosensor_pkg::BIT_ENABLE] & ~bio_on;
   wire       prox_on   = main_bio[biosensor_pkg::BIT_ENABLE]
                          & (mode == biosensor_pkg::MODE_PROX);
   wire       idle_mode = ~(main_light[biosensor_pkg::BIT_ENABLE]
                            | main_bio[biosensor_pkg::BIT_ENABLE]);

   ////////////////////////////////////////////////////////////////////////////
   // Bus event decoding

   wire addr_done = (state == S_ADDR) & scl_fall & (bitcnt == 4'h8);
   wire addr_hit  = shreg[7:1] == biosensor_pkg::DEV_ADDR;
   wire rx_done   = (state == S_RX) & scl_fall & (bitcnt == 4'h8);
   wire host_wr   = rx_done & idx_loaded;
   wire fetch     = scl_fall & ((state == S_ACK_ADDR & rw) | (state == S_ACK_TX & ~mack));
   wire wr_hit_wr = host_wr & (idx == biosensor_pkg::OFS_WR_PTR);
   wire wr_hit_rd = host_wr & (idx == biosensor_pkg::OFS_RD_PTR);
   wire wr_hit_ov = host_wr & (idx == biosensor_pkg::OFS_OVF);
   wire rd_status = fetch & (idx == biosensor_pkg::OFS_STATUS);
   wire rd_data   = fetch & (idx == biosensor_pkg::OFS_DATA);
   wire data_pop  = rd_data & (byte_sel == 2'h2);
   // Host reading inside the FIFO block holds off the sample writer
   wire fifo_busy = rw & (state == S_TX | state == S_ACK_TX)
                    & (idx >= biosensor_pkg::OFS_WR_PTR) & (idx <= biosensor_pkg::OFS_DATA);

   ////////////////////////////////////////////////////////////////////////////
   // FIFO pointer, level and overflow next values

   wire       sample_take = sample_evt & bio_on & ~fifo_busy;
   wire       sample_lost = sample_evt & bio_on & fifo_busy;
   wire       fifo_full   = level == DEPTH_L;
   wire [7:0] ovf_inc     = (ovf == 8'hff) ? ovf : ovf + 8'h01;
   wire [PTR_W:0] almost_full_flag_at = DEPTH_L - (PTR_W+1)'(fifo_cfg[biosensor_pkg::THR_W-1:0]);

   logic [PTR_W-1:0] next_wr;
   logic [PTR_W-1:0] next_rd;
   logic [PTR_W:0]   next_level;
   logic [7:0]       next_ovf;

   // Host pointer writes win over the sample writer in the same cycle
   always_comb
   begin
      next_wr    = wr_ptr;
      next_rd    = rd_ptr;
      next_level = level;
      next_ovf   = ovf;
      if (sample_take)
      begin
         next_wr = wr_ptr + 1'b1;
         if (fifo_full)
         begin
            next_rd  = rd_ptr + 1'b1;
            next_ovf = ovf_inc;
         end
         else
            next_level = level + 1'b1;
      end
      if (sample_lost)
         next_ovf = ovf_inc;
      if (data_pop)
      begin
         next_rd = rd_ptr + 1'b1;
         if (level != '0)
            next_level = level - 1'b1;
      end
      if (wr_hit_wr)
         next_wr = shreg[PTR_W-1:0];
      if (wr_hit_rd)
         next_rd = shreg[PTR_W-1:0];
      if (wr_hit_ov)
         next_ovf = shreg;
      if (wr_hit_wr | wr_hit_rd)
         next_level = {1'b0, next_wr - next_rd};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags: a new event wins over a read that clears it

   wire drdy_evt  = sample_take & (~dual | pair_phase);
   wire almost_full_flag_evt = sample_take & (next_level >= almost_full_flag_at);
   wire next_drdy  = drdy_evt | (st_drdy & ~rd_status);
   wire next_almost_full_flag = almost_full_flag_evt | (st_almost_full_flag & ~rd_status & ~rd_data);
   wire int_req   = (st_drdy & int_cfg[biosensor_pkg::BIT_DRDY_EN])
                    | (st_almost_full_flag & int_cfg[biosensor_pkg::BIT_ALMOST_FULL_FLAG_EN]);

   ////////////////////////////////////////////////////////////////////////////
   // Register read selection, sample bytes least significant first

   wire [SAMPLE_W-1:0] head = ram[rd_ptr];
   logic [7:0] rd_byte;

   always_comb
   begin
      unique case (idx)
         biosensor_pkg::OFS_STATUS:     rd_byte = {6'h00, st_almost_full_flag, st_drdy};
         biosensor_pkg::OFS_MAIN_LIGHT: rd_byte = main_light;
         biosensor_pkg::OFS_MAIN_BIO:   rd_byte = main_bio;
         biosensor_pkg::OFS_INT_CFG:    rd_byte = int_cfg;
         biosensor_pkg::OFS_FIFO_CFG:   rd_byte = fifo_cfg;
         biosensor_pkg::OFS_WR_PTR:     rd_byte = 8'(wr_ptr);
         biosensor_pkg::OFS_RD_PTR:     rd_byte = 8'(rd_ptr);
         biosensor_pkg::OFS_OVF:        rd_byte = ovf;
         biosensor_pkg::OFS_DATA:       rd_byte = head[8*byte_sel +: 8];
         default:                       rd_byte = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-wire engine next state

   always_comb
   begin
      next_state  = state;
      next_shreg  = shreg;
      next_bitcnt = bitcnt;
      unique case (state)
         S_IDLE:
            next_state = S_IDLE;
         S_ADDR, S_RX:
         begin
            if (scl_rise)
            begin
               next_shreg  = {shreg[6:0], sda_s[1]};
               next_bitcnt = bitcnt + 4'h1;
            end
            if (addr_done)
               next_state = addr_hit ? S_ACK_ADDR : S_IDLE;
            if (rx_done)
               next_state = S_ACK_RX;
         end
         S_ACK_ADDR, S_ACK_RX:
         begin
            if (scl_fall)
            begin
               next_state  = (state == S_ACK_ADDR & rw) ? S_TX : S_RX;
               next_bitcnt = 4'h0;
            end
         end
         S_TX:
         begin
            if (scl_fall)
            begin
               next_shreg  = {shreg[6:0], 1'b0};
               next_bitcnt = bitcnt + 4'h1;
               if (bitcnt == 4'h7)
                  next_state = S_ACK_TX;
            end
         end
         S_ACK_TX:
         begin
            // Master not-acknowledge ends the read without a further fetch
            if (scl_fall)
            begin
               next_state  = mack ? S_IDLE : S_TX;
               next_bitcnt = 4'h0;
            end
         end
      endcase
      if (fetch)
         next_shreg = rd_byte;
      if (start_det)
      begin
         next_state  = S_ADDR;
         next_bitcnt = 4'h0;
      end
      if (stop_det)
         next_state = S_IDLE;
   end

   // Pull data low for acknowledges and for transmitted zeros
   wire next_sda_oe = (next_state == S_ACK_ADDR) | (next_state == S_ACK_RX)
                      | ((next_state == S_TX) & ~next_shreg[7]);

   ////////////////////////////////////////////////////////////////////////////
   // Two-wire engine flops

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state  <= S_IDLE;
         shreg  <= 8'h00;
         bitcnt <= 4'h0;
         sda_oe <= 1'b0;
      end
      else
      begin
         state  <= next_state;
         shreg  <= next_shreg;
         bitcnt <= next_bitcnt;
         sda_oe <= next_sda_oe;
      end
   end

   // Index auto-increment stops at the data register
   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         idx        <= 8'h00;
         idx_loaded <= 1'b0;
         rw         <= 1'b0;
         mack       <= 1'b1;
      end
      else
      begin
         if (addr_done & addr_hit)
            rw <= shreg[0];
         if (addr_done & addr_hit & ~shreg[0])
            idx_loaded <= 1'b0;
         if (rx_done & ~idx_loaded)
         begin
            idx        <= shreg;
            idx_loaded <= 1'b1;
         end
         if ((host_wr | fetch) & (idx != biosensor_pkg::OFS_DATA))
            idx <= idx + 8'h01;
         if (state == S_ACK_TX & scl_rise)
            mack <= sda_s[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers; software reset takes one cycle after the write

   wire wr_light = host_wr & (idx == biosensor_pkg::OFS_MAIN_LIGHT);

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         main_light <= biosensor_pkg::RST_REG;
         main_bio   <= biosensor_pkg::RST_REG;
         int_cfg    <= biosensor_pkg::RST_REG;
         fifo_cfg   <= biosensor_pkg::RST_REG;
         sw_rst     <= 1'b0;
      end
      else if (sw_rst)
      begin
         main_light <= biosensor_pkg::RST_REG;
         main_bio   <= biosensor_pkg::RST_REG;
         int_cfg    <= biosensor_pkg::RST_REG;
         fifo_cfg   <= biosensor_pkg::RST_REG;
         sw_rst     <= 1'b0;
      end
      else
      begin
         sw_rst <= wr_light & shreg[biosensor_pkg::BIT_SW_RESET];
         if (wr_light)
            main_light <= shreg;
         if (host_wr & (idx == biosensor_pkg::OFS_MAIN_BIO))
            main_bio <= shreg;
         if (host_wr & (idx == biosensor_pkg::OFS_INT_CFG))
            int_cfg <= shreg;
         if (host_wr & (idx == biosensor_pkg::OFS_FIFO_CFG))
            fifo_cfg <= shreg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // FIFO bookkeeping and status flags

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         wr_ptr     <= '0;
         rd_ptr     <= '0;
         level      <= '0;
         ovf        <= biosensor_pkg::RST_REG;
         byte_sel   <= 2'h0;
         pair_phase <= 1'b0;
         st_drdy    <= 1'b0;
         st_almost_full_flag   <= 1'b0;
      end
      else if (sw_rst)
      begin
         wr_ptr     <= '0;
         rd_ptr     <= '0;
         level      <= '0;
         ovf        <= biosensor_pkg::RST_REG;
         byte_sel   <= 2'h0;
         pair_phase <= 1'b0;
         st_drdy    <= 1'b0;
         st_almost_full_flag   <= 1'b0;
      end
      else
      begin
         wr_ptr   <= next_wr;
         rd_ptr   <= next_rd;
         level    <= next_level;
         ovf      <= next_ovf;
         st_drdy  <= next_drdy;
         st_almost_full_flag <= next_almost_full_flag;
         if (rd_data)
            byte_sel <= data_pop ? 2'h0 : byte_sel + 2'h1;
         else if (wr_hit_rd)
            byte_sel <= 2'h0;
         if (~dual)
            pair_phase <= 1'b0;
         else if (sample_evt)
            pair_phase <= ~pair_phase;
      end
   end

   // Sample RAM, written only while the host is not reading it
   always_ff @(posedge CLK)
   begin
      if (sample_take)
         ram[wr_ptr] <= bio_hold;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         int_oe    <= 1'b0;
         light_run <= 1'b0;
         prox_run  <= 1'b0;
         bio_run   <= 1'b0;
         dual_led  <= 1'b0;
         standby   <= 1'b1;
      end
      else
      begin
         int_oe    <= int_req;
         light_run <= light_on;
         prox_run  <= prox_on & ~bio_on;
         bio_run   <= bio_on;
         dual_led  <= dual;
         standby   <= idle_mode;
      end
   end

   // Open-drain pins only ever pull low
   assign SDA_OUT   = 1'b0;
   assign SDA_OE    = sda_oe;
   assign INT_OUT   = 1'b0;
   assign INT_OE    = int_oe;
   assign LIGHT_RUN = light_run;
   assign PROX_RUN  = prox_run;
   assign BIO_RUN   = bio_run;
   assign DUAL_LED  = dual_led;
   assign STANDBY   = standby;

endmodule // biosensor_core

// ---- shared/biosensor_pkg.sv ----
// Constants shared by the biosensor mode control and sample FIFO
package biosensor_pkg;

   // Bus address of the device
   localparam logic [6:0] DEV_ADDR       = 7'h53;

   // Register offsets
   localparam logic [7:0] OFS_STATUS     = 8'h00;
   localparam logic [7:0] OFS_MAIN_LIGHT = 8'h15;
   localparam logic [7:0] OFS_MAIN_BIO   = 8'h16;
   localparam logic [7:0] OFS_INT_CFG    = 8'h2c;
   localparam logic [7:0] OFS_FIFO_CFG   = 8'h37;
   localparam logic [7:0] OFS_WR_PTR     = 8'h38;
   localparam logic [7:0] OFS_RD_PTR     = 8'h39;
   localparam logic [7:0] OFS_OVF        = 8'h3a;
   localparam logic [7:0] OFS_DATA       = 8'h3b;

   // Field positions
   localparam int BIT_ENABLE   = 0;
   localparam int BIT_SW_RESET = 7;
   localparam int MODE_LSB     = 1;
   localparam int BIT_DRDY     = 0;
   localparam int BIT_ALMOST_FULL_FLAG    = 1;
   localparam int BIT_DRDY_EN  = 4;
   localparam int BIT_ALMOST_FULL_FLAG_EN = 5;
   localparam int THR_W        = 4;

   // Bio and proximity mode encodings
   localparam logic [1:0] MODE_PROX       = 2'h0;
   localparam logic [1:0] MODE_BIO_SINGLE = 2'h1;
   localparam logic [1:0] MODE_BIO_DUAL   = 2'h2;

   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;

   // Sample store geometry
   localparam int FIFO_DEPTH   = 32;
   localparam int SAMPLE_BYTES = 3;

endpackage

// ---- testbench/biosensor_host.sv ----
// Two-wire host controller model for the biosensor register bus
`timescale 1ns/1ps
module biosensor_host
(
   input  wire logic       clk,    // Bit timing reference
   input  wire logic       sda,    // Resolved data wire
   output logic            scl,    // Bus clock, idles high
   output logic            sda_oe, // Host pulls data low
   output logic [7:0]      rdata,  // Last byte read
   output int              nread,  // Bytes read so far
   output int              nak     // Missing acknowledges
);
   initial
   begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Quarter bit: keeps both clock phases well above four system clocks
   task automatic q();
      repeat (3) @(negedge clk);
   endtask
   // Data set while clock low, sampled mid clock high
   task automatic bit_io(input logic b, output logic s);
      sda_oe = !b;
      q();
      scl = 1'b1;
      q();
      s = sda;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic start();
      sda_oe = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_oe = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask
   // Stop, then an idle gap so the device can update its store
   task automatic stop();
      sda_oe = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_oe = 1'b0;
      repeat (20) @(negedge clk);
   endtask
   task automatic put(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      nak += int'(s);
   endtask
   // Only the final byte is refused, so whole samples are taken
   task automatic get(input logic last);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, s);
         rdata[i] = s;
      end
      nread++;
      bit_io(last, s);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic write_reg(input logic [7:0] idx, input logic [7:0] d);
      start();
      put({biosensor_pkg::DEV_ADDR, 1'b0});
      put(idx);
      put(d);
      stop();
   endtask
   // Index write, repeated start, then a burst of n bytes
   task automatic read_regs(input logic [7:0] idx, input int n);
      start();
      put({biosensor_pkg::DEV_ADDR, 1'b0});
      put(idx);
      start();
      put({biosensor_pkg::DEV_ADDR, 1'b1});
      for (int i = 0; i < n; i++)
         get(i == n - 1);
      stop();
   endtask
endmodule // biosensor_host

// ---- testbench/biosensor_props.sv ----
// Port-level assertions for the biosensor core
`timescale 1ns/1ps
module biosensor_props
(
   input wire logic CLK,       // System clock
   input wire logic NRST,      // Async reset, active low
   input wire logic SCL,       // Bus clock pin
   input wire logic SDA_OUT,   // Data drive value
   input wire logic SDA_OE,    // Data pull-down enable
   input wire logic INT_OUT,   // Interrupt drive value
   input wire logic INT_OE,    // Interrupt pull-down enable
   input wire logic LIGHT_RUN, // Light active
   input wire logic PROX_RUN,  // Proximity active
   input wire logic BIO_RUN,   // Bio active
   input wire logic STANDBY    // Standby flag
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   ////////////////////////////////////////////////////////////////////////////
   // Mode flags against each other
   a_standby_no_run: assert property (STANDBY |-> !LIGHT_RUN && !PROX_RUN && !BIO_RUN)
      else $error("measurement runs in standby");
   a_awake_runs: assert property (!STANDBY |-> LIGHT_RUN || PROX_RUN || BIO_RUN)
      else $error("awake without any measurement");
   a_bio_exclusive: assert property (BIO_RUN |-> !LIGHT_RUN && !PROX_RUN)
      else $error("light or proximity beside bio");
   a_reset_defaults: assert property ($rose(NRST) |-> STANDBY && !INT_OE && !SDA_OE)
      else $error("outputs not at defaults after reset");
   ////////////////////////////////////////////////////////////////////////////
   // Pins: open drain only, bus data moves while the bus clock is low
   a_open_drain: assert property (!SDA_OUT && !INT_OUT)
      else $error("open-drain pin driven high");
   a_sda_scl_low: assert property ($changed(SDA_OE) |-> !SCL)
      else $error("data pin moved while bus clock high");
   a_int_level: assert property ($rose(INT_OE) |=> INT_OE [*3])
      else $error("interrupt dropped right after rising");
   a_int_clear_fetch: assert property ($fell(INT_OE) |-> !SCL)
      else $error("interrupt released outside a byte fetch");
endmodule // biosensor_props
bind biosensor_core biosensor_props u_props (.CLK(CLK), .NRST(NRST), .SCL(SCL), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .INT_OUT(INT_OUT), .INT_OE(INT_OE), .LIGHT_RUN(LIGHT_RUN), .PROX_RUN(PROX_RUN),
   .BIO_RUN(BIO_RUN), .STANDBY(STANDBY));

// ---- testbench/testbench.sv ----
// Self-checking bench for the biosensor mode control and sample FIFO
`timescale 1ns/1ps
module testbench;
   logic        clk;
   logic        nrst;
   logic        bio_clk;
   logic        bio_valid;
   logic [23:0] bio_data;
   logic [23:0] d [3];
   logic [7:0]  rdata;
   logic [7:0]  expq [$];
   wire logic   scl, h_oe, sda_oe, int_oe, light_run, prox_run, bio_run, standby;
   wire logic   sda_out, int_out, dual_led;
   // Device pull-down only counts while its drive value is low
   wire logic   sda = !(h_oe || (sda_oe && !sda_out));
   int          nread, nak, mismatches, checked, cycles;
   biosensor_core uut (.CLK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
      .INT_OUT(int_out), .INT_OE(int_oe), .BIO_CLK(bio_clk), .BIO_VALID(bio_valid), .BIO_DATA(bio_data),
      .LIGHT_RUN(light_run), .PROX_RUN(prox_run), .BIO_RUN(bio_run), .DUAL_LED(dual_led),
      .STANDBY(standby));
   biosensor_host host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(h_oe), .rdata(rdata), .nread(nread),
      .nak(nak));
   ////////////////////////////////////////////////////////////////////////////
   // Clocks with unrelated phases
   initial
   begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   initial
   begin
      bio_clk = 1'b0;
      #3;
      forever #16 bio_clk = !bio_clk;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Each byte the host reads is matched with the oldest note
   always @(nread)
      check("read byte", rdata, expq.pop_front());
   // Hang guard, about three times the thirteen thousand or so cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // One conversion; spacing well above the eight-cycle minimum
   task automatic sample(output logic [23:0] v);
      @(negedge bio_clk);
      v = 24'($urandom);
      bio_data = v;
      bio_valid = 1'b1;
      @(negedge bio_clk);
      bio_valid = 1'b0;
      repeat (4) @(negedge bio_clk);
   endtask
   task automatic flags(input logic [7:0] exp);
      repeat (12) @(negedge clk);
      check("mode flags", {sda_out, int_out, dual_led, int_oe, standby, light_run, prox_run, bio_run}, exp);
   endtask
   task automatic note(input logic [23:0] v);
      expq.push_back(v[7:0]);
      expq.push_back(v[15:8]);
      expq.push_back(v[23:16]);
   endtask
   initial
   begin
      nrst = 1'b0;
      bio_valid = 1'b0;
      bio_data = 24'h000000;
      void'($urandom(32'h88c8));
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      flags(8'h08);
      repeat (5) expq.push_back(8'h00);
      host.read_regs(biosensor_pkg::OFS_MAIN_LIGHT, 2);
      host.read_regs(biosensor_pkg::OFS_WR_PTR, 3);
      host.write_reg(biosensor_pkg::OFS_MAIN_LIGHT, 8'h01);
      flags(8'h04);
      host.write_reg(biosensor_pkg::OFS_FIFO_CFG, 8'h0c);
      host.write_reg(biosensor_pkg::OFS_INT_CFG, 8'h10);
      host.write_reg(biosensor_pkg::OFS_WR_PTR, 8'h00);
      host.write_reg(biosensor_pkg::OFS_RD_PTR, 8'h00);
      host.write_reg(biosensor_pkg::OFS_MAIN_BIO, 8'h03);
      flags(8'h01);
      for (int i = 0; i < 3; i++)
         sample(d[i]);
      flags(8'h11);
      // Burst: pointers, overflow, two samples low byte first
      expq.push_back(8'h03);
      expq.push_back(8'h00);
      expq.push_back(8'h00);
      note(d[0]);
      note(d[1]);
      host.read_regs(biosensor_pkg::OFS_WR_PTR, 9);
      expq.push_back(8'h02);
      host.read_regs(biosensor_pkg::OFS_RD_PTR, 1);
      expq.push_back(8'h01);
      host.read_regs(biosensor_pkg::OFS_STATUS, 1);
      flags(8'h01);
      // Almost full with twelve slots left: level 20 exactly
      host.write_reg(biosensor_pkg::OFS_INT_CFG, 8'h20);
      for (int i = 0; i < 19; i++)
      begin
         sample(bio_data);
         if (i == 17)
            flags(8'h01);
      end
      flags(8'h11);
      note(d[2]);
      host.read_regs(biosensor_pkg::OFS_DATA, 3);
      flags(8'h01);
      // Dual LED: data ready only once both of a pair are in
      expq.push_back(8'h01);
      host.read_regs(biosensor_pkg::OFS_STATUS, 1);
      host.write_reg(biosensor_pkg::OFS_INT_CFG, 8'h10);
      host.write_reg(biosensor_pkg::OFS_WR_PTR, 8'h00);
      host.write_reg(biosensor_pkg::OFS_RD_PTR, 8'h00);
      host.write_reg(biosensor_pkg::OFS_MAIN_BIO, 8'h05);
      flags(8'h21);
      sample(d[0]);
      flags(8'h21);
      sample(d[1]);
      flags(8'h31);
      expq.push_back(8'h02);
      expq.push_back(8'h00);
      expq.push_back(8'h00);
      note(d[0]);
      note(d[1]);
      host.read_regs(biosensor_pkg::OFS_WR_PTR, 9);
      // Light and proximity together once bio is off
      host.write_reg(biosensor_pkg::OFS_MAIN_BIO, 8'h01);
      flags(8'h16);
      host.write_reg(biosensor_pkg::OFS_MAIN_LIGHT, 8'h00);
      host.write_reg(biosensor_pkg::OFS_MAIN_BIO, 8'h02);
      flags(8'h18);
      expq.push_back(8'h0c);
      host.read_regs(biosensor_pkg::OFS_FIFO_CFG, 1);
      host.write_reg(biosensor_pkg::OFS_MAIN_LIGHT, 8'h80);
      expq.push_back(8'h00);
      host.read_regs(biosensor_pkg::OFS_FIFO_CFG, 1);
      check("missing acks", 8'(nak), 8'h00);
      check("notes left", 8'(expq.size()), 8'h00);
      end_of_test();
   end
endmodule // testbench
